// file: core/csc_pkg.sv
// Constants for the clock synthesizer, serializer and trigger configuration bank.
// Assumes a single system clock; serial control port pins are asynchronous.
package csc_pkg;
  // ==========================================================================
  // Serial control port frame
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned ADDR_BITS  = 15;
  localparam logic [4:0]  CNT_ADDR   = 5'h0f;
  localparam logic [4:0]  CNT_LAST   = 5'h17;
  // ==========================================================================
  // Register offsets
  localparam logic [14:0] ADDR_FBDIV = 15'h003e;
  localparam logic [14:0] ADDR_BIAS  = 15'h003f;
  localparam logic [14:0] ADDR_PE    = 15'h0048;
  localparam logic [14:0] ADDR_TRIG  = 15'h0057;
  localparam logic [14:0] ADDR_OVR   = 15'h0058;
  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_FBDIV  = 8'h20;
  localparam logic [7:0]  RST_BIAS   = 8'h4f;
  localparam logic [7:0]  RST_PE     = 8'h00;
  localparam logic [7:0]  RST_TRIG   = 8'h00;
  localparam logic [7:0]  RST_OVR    = 8'h00;
  // ==========================================================================
  // Field positions
  localparam int unsigned NDIV_MSB   = 5;
  localparam int unsigned BIAS_MSB   = 6;
  localparam int unsigned PE_MSB     = 3;
  localparam int unsigned TRIG_EN    = 7;
  localparam int unsigned TMODE_MSB  = 2;
  localparam int unsigned OVR_EN     = 7;
  localparam int unsigned OVR_REFSEL = 1;
  localparam int unsigned OVR_SYNEN  = 0;
  localparam int unsigned LANES      = 8;
  // ==========================================================================
  // Trigger output modes
  typedef enum logic [2:0] {
    TMODE_UI16 = 3'h0,
    TMODE_UI32 = 3'h1,
    TMODE_UI64 = 3'h2,
    TMODE_TS   = 3'h3
  } csc_tmode_type;
endpackage : csc_pkg

// file: core/csc_spi_slave.sv
// Serial control port slave: 1 r/w bit, 15 address bits, 8 data bits, MSB first.
// Assumes SCLK well below a quarter of the system clock rate.
`timescale 1ns/1ps
`default_nettype none
module csc_spi_slave
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // Pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  // Register side
  output logic             wr_stb,
  output logic [14:0]      addr,
  output logic [7:0]       wdata,
  input  wire logic [7:0]  rdata
);
  // ==========================================================================
  // Synchronisers
  logic [2:0]  sclk_q;
  logic [1:0]  cs_q;
  logic [1:0]  sdi_q;
  logic [4:0]  cnt;
  logic [14:0] sh;
  logic [6:0]  out_sh;
  logic        rw;
  logic        loaded;
  logic        rise;
  logic        fall;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_q <= 3'h0;
      cs_q   <= 2'h3;
      sdi_q  <= 2'h0;
    end
    else if (ce)
    begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_q   <= {cs_q[0], cs_n};
      sdi_q  <= {sdi_q[0], sdi};
    end
  end

  // Edges judged on second and third stages only
  assign rise = sclk_q[1] & ~sclk_q[2] & ~cs_q[1];
  assign fall = ~sclk_q[1] & sclk_q[2] & ~cs_q[1];

  // ==========================================================================
  // Shift in
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt    <= 5'h00;
      sh     <= 15'h0000;
      rw     <= 1'b0;
      addr   <= 15'h0000;
      wdata  <= 8'h00;
      wr_stb <= 1'b0;
    end
    else if (ce)
    begin
      wr_stb <= 1'b0;
      if (cs_q[1])
        cnt <= 5'h00;
      else if (rise)
      begin
        sh <= {sh[13:0], sdi_q[1]};
        if (cnt != 5'h1f)
          cnt <= cnt + 5'h01;
        if (cnt == csc_pkg::CNT_ADDR)
        begin
          rw   <= sh[14];
          addr <= {sh[13:0], sdi_q[1]};
        end
        if (cnt == csc_pkg::CNT_LAST)
        begin
          wdata  <= {sh[6:0], sdi_q[1]};
          wr_stb <= ~rw;
        end
      end
    end
  end

  // ==========================================================================
  // Shift out on falling edges once the address is known
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sdo    <= 1'b0;
      out_sh <= 7'h00;
      loaded <= 1'b0;
    end
    else if (ce)
    begin
      if (cs_q[1])
        loaded <= 1'b0;
      else if (fall && rw && cnt == 5'h10 && !loaded)
      begin
        sdo    <= rdata[7];
        out_sh <= rdata[6:0];
        loaded <= 1'b1;
      end
      else if (fall && loaded)
      begin
        sdo    <= out_sh[6];
        out_sh <= {out_sh[5:0], 1'b0};
      end
    end
  end

  assign sdo_oe = loaded & ~cs_q[1];
endmodule : csc_spi_slave
`default_nettype wire

// file: core/csc_config_top.sv
// Configuration bank: synthesizer divider and bias, lane emphasis, trigger output,
// synthesizer pin override. Pins arrive asynchronous; tick inputs are on CLK_SYS.
// Function
// - Divider field bits 5:0 divides by its own value, 1 to 63.
// - Divider makes feedback tick from sample ticks; resets to 0x20.
// - Emphasis bits 3:0 drive every lane identically; reset to zero.
// - Trigger control bit 7 enables trigger output; resets to zero.
// - Mode 0/1/2 give 16/32/64 UI clock, 3 timestamp, 4-7 reserved.
// - Serializer-derived modes hold output low and restart their count while the serializer reinitializes.
// - Override bit 7 takes synthesizer controls from register, not pins.
`timescale 1ns/1ps
`default_nettype none
module csc_config_top
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  // Serial control port
  input  wire logic        SPI_SCLK,
  input  wire logic        SPI_CS_N,
  input  wire logic        SPI_SDI,
  output logic             SPI_SDO,
  output logic             SPI_SDO_OE,
  // Configuration pins and timestamp
  input  wire logic        SYNTH_EN_PIN,
  input  wire logic        REF_SEL_PIN,
  input  wire logic        CLKCFG0_PIN,
  input  wire logic        CLKCFG1_PIN,
  input  wire logic        TIMESTAMP_INPUT,
  // Same-domain ticks from the clock path and serializer
  input  wire logic        SAMPLE_TICK,
  input  wire logic        UI8_TICK,
  input  wire logic        SER_REINIT,
  // Synthesizer controls
  output logic             FB_TICK,
  output logic [6:0]       OSC_BIAS,
  output logic             SYNTH_ENABLE,
  output logic             SYNTH_REF_SELECT,
  output logic [1:0]       REF_DIV_C_MODE,
  output logic [1:0]       REF_DIV_D_MODE,
  // Lanes and trigger
  output logic [31:0]      LANE_EMPHASIS,
  output logic             TRIG_ENABLE,
  output logic             TRIG_OUT
);
  // ==========================================================================
  // Register bank
  logic [7:0]  synth_feedback_divider_n;
  logic [7:0]  synth_oscillator_bias;
  logic [7:0]  lane_pre_emphasis;
  logic [7:0]  trigger_output_control;
  logic [7:0]  synth_pin_override;
  logic        wr_stb;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;

  csc_spi_slave u_spi
  (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .ce     (CE),
    .sclk   (SPI_SCLK),
    .cs_n   (SPI_CS_N),
    .sdi    (SPI_SDI),
    .sdo    (SPI_SDO),
    .sdo_oe (SPI_SDO_OE),
    .wr_stb (wr_stb),
    .addr   (addr),
    .wdata  (wdata),
    .rdata  (rdata)
  );

  // All eight bits stored so reserved bits read back as written
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      synth_feedback_divider_n <= csc_pkg::RST_FBDIV;
      synth_oscillator_bias    <= csc_pkg::RST_BIAS;
      lane_pre_emphasis        <= csc_pkg::RST_PE;
      trigger_output_control   <= csc_pkg::RST_TRIG;
      synth_pin_override       <= csc_pkg::RST_OVR;
    end
    else if (CE && wr_stb)
    begin
      case (addr)
        csc_pkg::ADDR_FBDIV: synth_feedback_divider_n <= wdata;
        csc_pkg::ADDR_BIAS:  synth_oscillator_bias    <= wdata;
        csc_pkg::ADDR_PE:    lane_pre_emphasis        <= wdata;
        csc_pkg::ADDR_TRIG:  trigger_output_control   <= wdata;
        csc_pkg::ADDR_OVR:   synth_pin_override       <= wdata;
        default:             ;
      endcase
    end
  end

  // Unmapped addresses read as zero
  always_comb
  begin
    case (addr)
      csc_pkg::ADDR_FBDIV: rdata = synth_feedback_divider_n;
      csc_pkg::ADDR_BIAS:  rdata = synth_oscillator_bias;
      csc_pkg::ADDR_PE:    rdata = lane_pre_emphasis;
      csc_pkg::ADDR_TRIG:  rdata = trigger_output_control;
      csc_pkg::ADDR_OVR:   rdata = synth_pin_override;
      default:             rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // Pin synchronisers
  logic [4:0] pin_q1;
  logic [4:0] pin_s;

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pin_q1 <= 5'h00;
      pin_s  <= 5'h00;
    end
    else if (CE)
    begin
      pin_q1 <= {TIMESTAMP_INPUT, CLKCFG1_PIN, CLKCFG0_PIN, REF_SEL_PIN, SYNTH_EN_PIN};
      pin_s  <= pin_q1;
    end
  end

  // ==========================================================================
  // Synthesizer controls
  logic       synth_override_enable;
  logic [5:0] n_div;
  logic [5:0] fb_cnt;

  assign synth_override_enable = synth_pin_override[csc_pkg::OVR_EN];
  assign n_div    = synth_feedback_divider_n[csc_pkg::NDIV_MSB:0];
  assign OSC_BIAS = synth_oscillator_bias[csc_pkg::BIAS_MSB:0];

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      SYNTH_ENABLE     <= 1'b0;
      SYNTH_REF_SELECT <= 1'b0;
      REF_DIV_C_MODE   <= 2'h0;
      REF_DIV_D_MODE   <= 2'h0;
    end
    else if (CE)
    begin
      if (synth_override_enable)
      begin
        SYNTH_ENABLE     <= synth_pin_override[csc_pkg::OVR_SYNEN];
        SYNTH_REF_SELECT <= synth_pin_override[csc_pkg::OVR_REFSEL];
        REF_DIV_C_MODE   <= synth_pin_override[3:2];
        REF_DIV_D_MODE   <= synth_pin_override[5:4];
      end
      else
      begin
        SYNTH_ENABLE     <= pin_s[0];
        SYNTH_REF_SELECT <= pin_s[1];
        REF_DIV_C_MODE   <= pin_s[3:2];
        REF_DIV_D_MODE   <= 2'h0;
      end
    end
  end

  // Divide-by-N; a value of zero is unsupported and stops the feedback tick
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      fb_cnt  <= 6'h00;
      FB_TICK <= 1'b0;
    end
    else if (CE)
    begin
      FB_TICK <= 1'b0;
      if (n_div == 6'h00)
        fb_cnt <= 6'h00;
      else if (SAMPLE_TICK)
      begin
        if (fb_cnt >= n_div - 6'h01)
        begin
          fb_cnt  <= 6'h00;
          FB_TICK <= 1'b1;
        end
        else
          fb_cnt <= fb_cnt + 6'h01;
      end
    end
  end

  // ==========================================================================
  // Lane emphasis, one copy per lane
  genvar g;
  generate
    for (g = 0; g < csc_pkg::LANES; g++)
    begin : g_lane
      always_ff @(posedge CLK_SYS or negedge ARST_N)
      begin
        if (!ARST_N)
          LANE_EMPHASIS[4*g +: 4] <= 4'h0;
        else if (CE)
          LANE_EMPHASIS[4*g +: 4] <= lane_pre_emphasis[csc_pkg::PE_MSB:0];
      end
    end
  endgenerate

  // ==========================================================================
  // Trigger output
  logic       trig_en;
  logic [2:0] trig_mode;
  logic [1:0] ui_cnt;
  logic       toggle;

  assign trig_en     = trigger_output_control[csc_pkg::TRIG_EN];
  assign trig_mode   = trigger_output_control[csc_pkg::TMODE_MSB:0];
  assign TRIG_ENABLE = trig_en;
  // Toggle every 8, 16 or 32 UI gives a 16, 32 or 64 UI period
  assign toggle = UI8_TICK &&
                  ((trig_mode == csc_pkg::TMODE_UI16) ||
                   (trig_mode == csc_pkg::TMODE_UI32 && ui_cnt[0]) ||
                   (trig_mode == csc_pkg::TMODE_UI64 && ui_cnt == 2'h3));

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ui_cnt   <= 2'h0;
      TRIG_OUT <= 1'b0;
    end
    else if (CE)
    begin
      if (!trig_en)
      begin
        ui_cnt   <= 2'h0;
        TRIG_OUT <= 1'b0;
      end
      else if (trig_mode == csc_pkg::TMODE_TS)
        TRIG_OUT <= pin_s[4];
      else if (trig_mode > csc_pkg::TMODE_TS)
        TRIG_OUT <= 1'b0;
      else if (SER_REINIT)
      begin
        ui_cnt   <= 2'h0;
        TRIG_OUT <= 1'b0;
      end
      else if (UI8_TICK)
      begin
        ui_cnt <= ui_cnt + 2'h1;
        if (toggle)
          TRIG_OUT <= ~TRIG_OUT;
      end
    end
  end

  // ==========================================================================
  // Assertions
  sequence s_wr_trig;
    CE && wr_stb && addr == csc_pkg::ADDR_TRIG;
  endsequence

  sequence s_ser_mode;
    CE && trig_en && trig_mode <= csc_pkg::TMODE_UI64;
  endsequence

  AST_FB_ZERO: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CE && n_div == 6'h00 |=> !FB_TICK)
    else $error("Feedback tick with zero divider");
  AST_FB_COUNT: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CE && SAMPLE_TICK && n_div != 6'h00 && fb_cnt == n_div - 6'h01 |=> FB_TICK && fb_cnt == 6'h00)
    else $error("Feedback tick missing at divider end");
  AST_LANES: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CE |=> LANE_EMPHASIS == {8{$past(lane_pre_emphasis[3:0])}})
    else $error("Lane emphasis differs from field");
  AST_TRIG_OFF: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CE && !trig_en |=> !TRIG_OUT && ui_cnt == 2'h0)
    else $error("Trigger active while disabled");
  AST_TRIG_TS: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CE && trig_en && trig_mode == csc_pkg::TMODE_TS |=> TRIG_OUT == $past(pin_s[4]))
    else $error("Trigger does not follow timestamp");
  AST_TRIG_RSV: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CE && trig_en && trig_mode[2] |=> !TRIG_OUT)
    else $error("Trigger active in reserved mode");
  AST_TRIG_UI16: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_ser_mode and (trig_mode == csc_pkg::TMODE_UI16 && UI8_TICK && !SER_REINIT)
    |=> TRIG_OUT != $past(TRIG_OUT))
    else $error("Trigger failed to toggle in 16 UI mode");
  AST_TRIG_REINIT: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_ser_mode and SER_REINIT |=> !TRIG_OUT)
    else $error("Trigger running during serializer reinit");
  AST_OVR_REG: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CE && synth_override_enable |=> SYNTH_ENABLE == $past(synth_pin_override[0])
    && REF_DIV_D_MODE == $past(synth_pin_override[5:4]))
    else $error("Override register not applied");
  AST_OVR_PIN: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    CE && !synth_override_enable |=> SYNTH_ENABLE == $past(pin_s[0]))
    else $error("Pin mode not applied");
  AST_READBACK: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_wr_trig |=> trigger_output_control == $past(wdata))
    else $error("Register does not hold written value");
endmodule : csc_config_top
`default_nettype wire

// file: dv/test_clock_pll_serdes_trigger_config.sv
// Self-checking bench for the configuration bank: serial port, divider, trigger, override.
// Assumes csc_pkg and csc_config_top are compiled first; one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_clock_pll_serdes_trigger_config;
  // ==========================================================================
  // Signals
  logic        clk_sys, arst_n, ce, sclk, cs_n, sdi, sdo, sdo_oe;
  logic        en_pin, rs_pin, c0_pin, c1_pin, ts_pin, stick, u8tick, reinit;
  logic        fb_tick, synth_en, ref_sel, trig_en, trig_out, prev_trig, res_vld;
  logic [6:0]  osc_bias;
  logic [1:0]  c_mode, d_mode;
  logic [31:0] lane_emph, res_val;
  logic [31:0] notes[$];
  logic [2:0]  ts_hist;
  logic [7:0]  rd, wv, oe_q;
  logic [7:0]  wvs[5];
  int          miscompares, comparisons, cycles, fb_cnt, tog_cnt, seed, i, m;
  logic [14:0] addrs[5] = '{15'h003e, 15'h003f, 15'h0048, 15'h0057, 15'h0058};
  logic [7:0]  rsts[5]  = '{8'h20, 8'h4f, 8'h00, 8'h00, 8'h00};
  int          nlist[4] = '{1, 2, 5, 63};
  int          togs[8]  = '{16, 8, 4, 0, 0, 0, 0, 0};

  csc_config_top dut
  (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .CE(ce),
    .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_SDI(sdi), .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe),
    .SYNTH_EN_PIN(en_pin), .REF_SEL_PIN(rs_pin), .CLKCFG0_PIN(c0_pin), .CLKCFG1_PIN(c1_pin),
    .TIMESTAMP_INPUT(ts_pin), .SAMPLE_TICK(stick), .UI8_TICK(u8tick), .SER_REINIT(reinit),
    .FB_TICK(fb_tick), .OSC_BIAS(osc_bias), .SYNTH_ENABLE(synth_en),
    .SYNTH_REF_SELECT(ref_sel), .REF_DIV_C_MODE(c_mode), .REF_DIV_D_MODE(d_mode),
    .LANE_EMPHASIS(lane_emph), .TRIG_ENABLE(trig_en), .TRIG_OUT(trig_out)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Watchers: counters by non-blocking update so drivers read settled values
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    prev_trig <= trig_out;
    ts_hist <= {ts_hist[1:0], ts_pin};
    if (fb_tick === 1'b1) fb_cnt <= fb_cnt + 1;
    if (trig_out !== prev_trig) tog_cnt <= tog_cnt + 1;
    if (cycles == 40000)
    begin
      miscompares++;
      final_report();
    end
  end

  always @(posedge clk_sys)
  begin
    if (res_vld === 1'b1) cmp(notes.pop_front(), res_val);
  end

  // ==========================================================================
  // Tasks
  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    notes.push_back(exp);
    res_val <= got;
    res_vld <= 1'b1;
    @(posedge clk_sys);
    res_vld <= 1'b0;
    @(posedge clk_sys);
  endtask : chk

  // Half periods of 6 cycles leave room for the 2-flop pin synchronisers
  task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [23:0] f;
    f = {rw, a, d};
    q = 8'h00;
    cs_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    for (int b = 23; b >= 0; b--)
    begin
      sclk <= 1'b0;
      sdi  <= f[b];
      repeat (6) @(posedge clk_sys);
      if (b < 8)
      begin
        q[b]    = sdo;
        oe_q[b] = sdo_oe;
      end
      sclk <= 1'b1;
      repeat (6) @(posedge clk_sys);
    end
    sclk <= 1'b0;
    cs_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : xfer

  // Count is phase independent: any start phase below the ratio gives the same total
  task automatic pulse(input logic sel, input int n, input int exp);
    int base;
    base = sel ? tog_cnt : fb_cnt;
    repeat (n)
    begin
      u8tick <= sel;
      stick  <= ~sel;
      @(posedge clk_sys);
      u8tick <= 1'b0;
      stick  <= 1'b0;
      @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
    chk(exp, (sel ? tog_cnt : fb_cnt) - base);
  endtask : pulse

  task automatic final_report();
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // ==========================================================================
  // Main sequence
  initial
  begin
    seed = 15125;
    ce   = 1'b1;
    {sclk, sdi, en_pin, rs_pin, c0_pin, c1_pin, ts_pin} = 7'h00;
    {stick, u8tick, reinit, res_vld, prev_trig, arst_n} = 6'h00;
    {cs_n, res_val, ts_hist} = {1'b1, 32'h0, 3'h0};
    {miscompares, comparisons, cycles, fb_cnt, tog_cnt} = '0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < 5; i++)
    begin
      xfer(1'b1, addrs[i], 8'h00, rd);
      chk({24'h0, rsts[i]}, {24'h0, rd});
    end
    chk(32'h4f, {25'h0, osc_bias});
    chk(32'h0, lane_emph);
    chk(32'h0, {31'h0, trig_en});
    pulse(1'b0, 128, 4);
    for (i = 0; i < 4; i++)
    begin
      xfer(1'b0, csc_pkg::ADDR_FBDIV, 8'(nlist[i]), rd);
      pulse(1'b0, 4 * nlist[i], 4);
    end
    xfer(1'b0, csc_pkg::ADDR_FBDIV, 8'h00, rd);
    pulse(1'b0, 64, 0);
    for (i = 0; i < 5; i++)
    begin
      wvs[i] = 8'($random(seed));
      xfer(1'b0, addrs[i], wvs[i], rd);
      chk(32'h0, {24'h0, oe_q});
      xfer(1'b1, addrs[i], 8'h00, rd);
      chk({24'h0, wvs[i]}, {24'h0, rd});
      chk(32'hff, {24'h0, oe_q});
    end
    chk({25'h0, wvs[1][6:0]}, {25'h0, osc_bias});
    chk({8{wvs[2][3:0]}}, lane_emph);
    chk({31'h0, wvs[3][7]}, {31'h0, trig_en});
    xfer(1'b0, csc_pkg::ADDR_BIAS, 8'h4a, rd);
    chk(32'h4a, {25'h0, osc_bias});
    xfer(1'b0, 15'h0040, 8'hff, rd);
    xfer(1'b1, 15'h0040, 8'h00, rd);
    chk(32'h0, {24'h0, rd});
    // Trigger modes: mode set while disabled, then enabled
    for (m = 0; m < 8; m++)
    begin
      xfer(1'b0, csc_pkg::ADDR_TRIG, {5'h00, m[2:0]}, rd);
      xfer(1'b0, csc_pkg::ADDR_TRIG, {5'h10, m[2:0]}, rd);
      chk(32'h1, {31'h0, trig_en});
      if (m == 3)
        repeat (12)
        begin
          ts_pin <= 1'($random(seed));
          chk({31'h0, ts_hist[2]}, {31'h0, trig_out});
        end
      else
        pulse(1'b1, 16, togs[m]);
    end
    xfer(1'b0, csc_pkg::ADDR_TRIG, 8'h00, rd);
    pulse(1'b1, 16, 0);
    xfer(1'b0, csc_pkg::ADDR_TRIG, 8'h80, rd);
    reinit <= 1'b1;
    pulse(1'b1, 16, 0);
    reinit <= 1'b0;
    pulse(1'b1, 16, 16);
    // Clock enable low freezes the trigger divider
    ce <= 1'b0;
    pulse(1'b1, 16, 0);
    ce <= 1'b1;
    // Synthesizer controls from pins, then from the override register
    xfer(1'b0, csc_pkg::ADDR_OVR, 8'h00, rd);
    {en_pin, rs_pin, c1_pin, c0_pin} <= 4'($random(seed));
    repeat (6) @(posedge clk_sys);
    chk({26'h0, en_pin, rs_pin, c1_pin, c0_pin, 2'b00},
        {26'h0, synth_en, ref_sel, c_mode, d_mode});
    wv = 8'h80 | (8'($random(seed)) & 8'h3f);
    xfer(1'b0, csc_pkg::ADDR_OVR, wv, rd);
    {en_pin, rs_pin, c1_pin, c0_pin} <= ~{en_pin, rs_pin, c1_pin, c0_pin};
    repeat (6) @(posedge clk_sys);
    chk({26'h0, wv[0], wv[1], wv[3:2], wv[5:4]},
        {26'h0, synth_en, ref_sel, c_mode, d_mode});
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule : test_clock_pll_serdes_trigger_config
`default_nettype wire
